// ---- logic/gpio_function_mapper.sv ----
// gpio function mapper: one pin mapped to device triggers and status
// assumes an avalon-mm master on the core clock and a static nvm image
//
// Behaviour
// - input-enable bit with output-enable clear makes pin an input
// - output-enable bit makes pin an output
// - channel actions only on selected channels
// - default configuration: pin does nothing
// - mapped pin disables matching software bit, but not the reset and unlock fields
// - low pulse on pin resets device
// - pin triggers keep software trigger conditions
// - pin reset only from nvm configuration
// - power-on: pin level runs its command, except for code 1011 reset
// - code 0000: fall sleeps, rise wakes
// - fault dump, protect, clear on fall
// - iout power and waveform per edge
// - vout power-down with chosen pulldown
// - code 1000: fall loads selected channels
// - code 1011: low pulse resets device
// - nvm and register write gating
// - output pin drives selected status
`timescale 1ns/100ps
module gpio_function_mapper (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	// register bus
	input wire logic [gpio_map_pkg::ADDR_W-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [gpio_map_pkg::DATA_W-1:0] i_avs_writedata,
	output logic [gpio_map_pkg::DATA_W-1:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// nvm image and device status
	input wire logic [gpio_map_pkg::CFG_W-1:0] i_nvm_cfg,
	input wire logic i_nvm_busy,
	input wire logic [gpio_map_pkg::NCH-1:0] i_dac_busy,
	input wire logic [gpio_map_pkg::NCH-1:0] i_win_cmp,
	// pin
	input wire logic i_gpio_in,
	output logic o_gpio_out,
	output logic o_gpio_oe,
	// device-wide triggers and levels
	output logic o_sleep_enter,
	output logic o_sleep_exit,
	output logic o_deep_sleep,
	output logic o_fault_dump,
	output logic o_protect,
	output logic o_output_clear_trigger,
	output logic o_device_reset,
	output logic o_nvm_prog,
	output logic o_nvm_prog_allowed,
	output logic o_reg_write_allowed,
	// per-channel triggers and levels
	output logic [gpio_map_pkg::NCH-1:0] o_output_load_trigger,
	output logic [gpio_map_pkg::NCH-1:0] o_margin_low,
	output logic [gpio_map_pkg::NCH-1:0] o_margin_high,
	output logic [gpio_map_pkg::NCH-1:0] o_iout_pd,
	output logic [gpio_map_pkg::NCH-1:0] o_vout_pd,
	output logic [2*gpio_map_pkg::NCH-1:0] o_voltage_powerdown_setting,
	output logic [gpio_map_pkg::NCH-1:0] o_func_run
);
	import gpio_map_pkg::*;
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		seq_t st; // sequencer state
		logic [SETTLE_W-1:0] settle; // synchroniser settle count
		logic [CFG_W-1:0] cfg; // pin configuration register
		logic [CH_W-1:0] chcfg; // channel configuration register
		logic sleep; // deep sleep level
		logic [NCH-1:0] iout_pd; // current output powered down
		logic [NCH-1:0] vout_pd; // voltage output powered down
		logic [NCH-1:0] run; // waveform generation running
		logic nvm_ok; // nvm programming allowed
		logic wr_ok; // register writes allowed
		logic low_seen; // low phase of a reset pulse seen
		logic ack; // bus answer cycle
		logic [DATA_W-1:0] rdata; // read data
		logic sl_in; // sleep enter pulse
		logic sl_out; // sleep exit pulse
		logic fault; // fault dump pulse
		logic prot; // protect pulse
		logic clr; // clear pulse
		logic rst; // device reset pulse
		logic nvm; // nvm program pulse
		logic [NCH-1:0] load; // load pulses
		logic [NCH-1:0] mlo; // margin low pulses
		logic [NCH-1:0] mhi; // margin high pulses
		logic gpo; // output pin value
	} map_state_t;
	map_state_t q, d;
	pin_edge_if pin_e ();
	// pin edge detector
	pin_edge_detect u_edge (
		.i_core_clk(i_core_clk),
		.i_sys_rst(i_sys_rst),
		.i_pin(i_gpio_in),
		.edge_o(pin_e)
	);
	// ----------------------------------------------------------------
	// decoded configuration
	// ----------------------------------------------------------------
	code_t fn; // input function code
	code_t ost; // output status code
	logic [NCH-1:0] sel; // input channel select
	logic [NCH-1:0] sync_en; // per-channel load sync setting
	logic pin_in; // pin acts as input
	logic fall_ev; // qualified falling event
	logic rise_ev; // qualified rising event
	logic nvm_rst_ok; // reset mapping held in nvm
	logic [DATA_W-1:0] wd; // write data alias
	assign fn = q.cfg[CFG_FN_LSB +: 4];
	assign ost = q.cfg[CFG_OST_LSB +: 4];
	assign sel = q.cfg[CFG_SEL_LSB +: NCH];
	assign sync_en = q.chcfg[CH_SYNC_LSB +: NCH];
	assign pin_in = q.cfg[CFG_IN_EN] & ~q.cfg[CFG_OUT_EN];
	assign nvm_rst_ok = i_nvm_cfg[CFG_IN_EN] & (i_nvm_cfg[CFG_FN_LSB +: 4] == FN_RESET);
	assign wd = i_avs_writedata;
	// sample at power-on acts as an edge towards the present level
	always_comb begin
		fall_ev = 1'b0;
		rise_ev = 1'b0;
		if (q.st == ST_RUN) begin
			fall_ev = pin_in & pin_e.fall;
			rise_ev = pin_in & pin_e.rise;
		end else if (q.st == ST_SAMPLE) begin
			fall_ev = pin_in & ~pin_e.level;
			rise_ev = pin_in & pin_e.level;
		end
	end
	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		d = q;
		// pulses last one cycle
		d.sl_in = 1'b0;
		d.sl_out = 1'b0;
		d.fault = 1'b0;
		d.prot = 1'b0;
		d.clr = 1'b0;
		d.rst = 1'b0;
		d.nvm = 1'b0;
		d.load = '0;
		d.mlo = '0;
		d.mhi = '0;
		d.ack = 1'b0;
		// sequencer: settle, reload from nvm, sample the pin
		case (q.st)
			ST_LOAD: begin
				d.cfg = i_nvm_cfg;
				if (q.settle == SETTLE_CYC) begin
					d.st = ST_SAMPLE;
				end else begin
					d.settle = q.settle + SETTLE_W'(1);
				end
			end
			ST_SAMPLE: begin
				d.st = ST_RUN;
			end
			default: begin
				d.st = ST_RUN;
			end
		endcase
		// pin function decode
		case (fn)
			FN_SLEEP: begin
				if (fall_ev && q.cfg[CFG_SLEEP_EN]) begin
					d.sleep = 1'b1;
					d.sl_in = 1'b1;
				end
				if (rise_ev && q.sleep) begin
					d.sleep = 1'b0;
					d.sl_out = 1'b1;
				end
			end
			FN_FAULT: d.fault = fall_ev;
			FN_PROT: d.prot = fall_ev;
			FN_CLR: d.clr = fall_ev;
			FN_IOUT: begin
				if (fall_ev) d.iout_pd = q.iout_pd | sel;
				if (rise_ev) d.iout_pd = q.iout_pd & ~sel;
			end
			FN_VOUT: begin
				if (fall_ev) d.vout_pd = q.vout_pd | sel;
				if (rise_ev) d.vout_pd = q.vout_pd & ~sel;
			end
			FN_LOAD: begin
				if (fall_ev) d.load = sel & sync_en;
			end
			FN_FUNC: begin
				if (fall_ev) d.run = q.run & ~sel;
				if (rise_ev) d.run = q.run | sel;
			end
			FN_MARGIN: begin
				if (fall_ev) d.mlo = sel;
				if (rise_ev) d.mhi = sel;
			end
			FN_RESET: begin
				// low phase arms, the return high fires the reset
				if (q.st == ST_RUN && pin_in && pin_e.fall) d.low_seen = 1'b1;
				if (q.st == ST_RUN && pin_in && pin_e.rise && q.low_seen && nvm_rst_ok) begin
					d.rst = 1'b1;
				end
			end
			FN_NVM: begin
				if (fall_ev) d.nvm_ok = 1'b1;
				if (rise_ev) d.nvm_ok = 1'b0;
			end
			FN_WRLOCK: begin
				if (fall_ev) d.wr_ok = 1'b1;
				if (rise_ev) d.wr_ok = 1'b0;
			end
			default: begin
				// unassigned codes take no action
				d.low_seen = q.low_seen;
			end
		endcase
		// ------------------------------------------------------------
		// register bus: one wait cycle, then the answer
		// ------------------------------------------------------------
		if ((i_avs_read || i_avs_write) && !q.ack) begin
			d.ack = 1'b1;
			d.rdata = '0;
			if (i_avs_address == OFF_CFG) begin
				d.rdata[CFG_W-1:0] = q.cfg;
			end else if (i_avs_address == OFF_STAT) begin
				d.rdata = {18'h00000, pin_e.level, q.wr_ok, q.nvm_ok, q.sleep,
					q.run, q.vout_pd, q.iout_pd, 4'h0};
			end else if (i_avs_address == OFF_CHCFG) begin
				d.rdata[CH_W-1:0] = q.chcfg;
			end else begin
				// trigger register and unmapped words read zero
				d.rdata = '0;
			end
		end
		if (i_avs_write && q.ack && q.st == ST_RUN) begin
			if (i_avs_address == OFF_CFG && q.wr_ok) begin
				d.cfg = wd[CFG_W-1:0];
			end else if (i_avs_address == OFF_CHCFG && q.wr_ok) begin
				d.chcfg = wd[CH_W-1:0];
			end else if (i_avs_address == OFF_TRIG) begin
				// unlock and reset fields pass even while writes are blocked
				if (wd[TRG_UNL_LSB +: 4] == UNLOCK_KEY) d.wr_ok = 1'b1;
				if (wd[TRG_RST_LSB] == RESET_KEY) d.rst = 1'b1;
				if (q.wr_ok) begin
					// a pin mapped to the same function masks the bit
					if (!(pin_in && fn == FN_PROT)) d.prot = d.prot | wd[TRG_PROT];
					if (!(pin_in && fn == FN_FAULT)) d.fault = d.fault | wd[TRG_FAULT];
					if (!(pin_in && fn == FN_CLR)) d.clr = d.clr | wd[TRG_CLR];
					if (!(pin_in && fn == FN_LOAD)) begin
						d.load = d.load | ({NCH{wd[TRG_LOAD]}} & sync_en);
					end
					if (!(pin_in && fn == FN_MARGIN)) begin
						d.mhi = d.mhi | wd[TRG_MHI_LSB +: NCH];
						d.mlo = d.mlo | wd[TRG_MLO_LSB +: NCH];
					end
					if (!(pin_in && fn == FN_FUNC)) begin
						d.run = d.run | wd[TRG_FUNC_LSB +: NCH];
					end
					d.nvm = wd[TRG_NVM] & q.nvm_ok;
				end
			end
		end
		// ------------------------------------------------------------
		// output pin status select
		// ------------------------------------------------------------
		case (ost)
			OST_NVM_BUSY: d.gpo = i_nvm_busy;
			OST_BUSY1: d.gpo = i_dac_busy[1];
			OST_BUSY0: d.gpo = i_dac_busy[0];
			OST_WIN1: d.gpo = i_win_cmp[1];
			OST_WIN0: d.gpo = i_win_cmp[0];
			default: d.gpo = 1'b0;
		endcase
		// a device reset clears the channel configuration and reloads nvm
		if (q.rst) begin
			d.st = ST_LOAD;
			d.settle = '0;
			d.low_seen = 1'b0;
			d.chcfg = CH_RESET;
		end
	end
	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			q <= '0;
			q.st <= ST_LOAD;
			q.cfg <= CFG_RESET;
			q.chcfg <= CH_RESET;
			q.nvm_ok <= 1'b1;
			q.wr_ok <= 1'b1;
		end else begin
			q <= d;
		end
	end
	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~q.ack;
	assign o_avs_readdata = q.rdata;
	assign o_gpio_out = q.gpo;
	assign o_gpio_oe = q.cfg[CFG_OUT_EN];
	assign o_sleep_enter = q.sl_in;
	assign o_sleep_exit = q.sl_out;
	assign o_deep_sleep = q.sleep;
	assign o_fault_dump = q.fault;
	assign o_protect = q.prot;
	assign o_output_clear_trigger = q.clr;
	assign o_device_reset = q.rst;
	assign o_nvm_prog = q.nvm;
	assign o_nvm_prog_allowed = q.nvm_ok;
	assign o_reg_write_allowed = q.wr_ok;
	assign o_output_load_trigger = q.load;
	assign o_margin_low = q.mlo;
	assign o_margin_high = q.mhi;
	assign o_iout_pd = q.iout_pd;
	assign o_vout_pd = q.vout_pd;
	assign o_voltage_powerdown_setting = q.chcfg[CH_PDN_LSB +: 2*NCH];
	assign o_func_run = q.run;
endmodule : gpio_function_mapper

// ---- logic/gpio_map_pkg.sv ----
// gpio function mapper package: register map, field layout, function codes
// assumes a 32-bit avalon-mm register bus with byte addresses
package gpio_map_pkg;
	// ----------------------------------------------------------------
	// bus and sizes
	// ----------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam int NCH = 2;
	localparam int CFG_W = 16;
	localparam int CH_W = 6;
	localparam int SETTLE_W = 2;
	localparam logic [SETTLE_W-1:0] SETTLE_CYC = 2'h3;
	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFF_CFG = 4'h0;
	localparam logic [ADDR_W-1:0] OFF_TRIG = 4'h4;
	localparam logic [ADDR_W-1:0] OFF_STAT = 4'h8;
	localparam logic [ADDR_W-1:0] OFF_CHCFG = 4'hC;
	// ----------------------------------------------------------------
	// pin configuration fields
	// ----------------------------------------------------------------
	localparam int CFG_IN_EN = 0;
	localparam int CFG_FN_LSB = 1;
	localparam int CFG_SEL_LSB = 5;
	localparam int CFG_OST_LSB = 9;
	localparam int CFG_OUT_EN = 13;
	localparam int CFG_SLEEP_EN = 14;
	localparam logic [CFG_W-1:0] CFG_RESET = 16'h0000;
	// channel configuration fields
	localparam int CH_PDN_LSB = 0;
	localparam int CH_SYNC_LSB = 4;
	localparam logic [CH_W-1:0] CH_RESET = 6'h00;
	// software trigger fields
	localparam int TRG_NVM = 0;
	localparam int TRG_PROT = 1;
	localparam int TRG_FAULT = 2;
	localparam int TRG_CLR = 3;
	localparam int TRG_LOAD = 4;
	localparam int TRG_MHI_LSB = 5;
	localparam int TRG_MLO_LSB = 7;
	localparam int TRG_FUNC_LSB = 9;
	localparam int TRG_RST_LSB = 8 + 3;
	localparam int TRG_UNL_LSB = 12;
	// reset and unlock keys, values arbitrary
	localparam logic [0:0] RESET_KEY = 1'h1;
	localparam logic [3:0] UNLOCK_KEY = 4'h5;
	// ----------------------------------------------------------------
	// input function and output status codes
	// ----------------------------------------------------------------
	typedef logic [3:0] code_t;
	localparam code_t FN_SLEEP = 4'h0;
	localparam code_t FN_FAULT = 4'h2;
	localparam code_t FN_IOUT = 4'h3;
	localparam code_t FN_VOUT = 4'h4;
	localparam code_t FN_PROT = 4'h5;
	localparam code_t FN_CLR = 4'h7;
	localparam code_t FN_LOAD = 4'h8;
	localparam code_t FN_FUNC = 4'h9;
	localparam code_t FN_MARGIN = 4'hA;
	localparam code_t FN_RESET = 4'hB;
	localparam code_t FN_NVM = 4'hC;
	localparam code_t FN_WRLOCK = 4'hD;
	localparam code_t OST_NVM_BUSY = 4'h1;
	localparam code_t OST_BUSY1 = 4'h4;
	localparam code_t OST_BUSY0 = 4'h7;
	localparam code_t OST_WIN1 = 4'h8;
	localparam code_t OST_WIN0 = 4'hB;
	// sequencer states
	typedef enum logic [1:0] {ST_LOAD, ST_SAMPLE, ST_RUN} seq_t;
endpackage : gpio_map_pkg

// ---- logic/pin_edge_detect.sv ----
// pin synchroniser and edge detector
// assumes i_pin is a raw pin level, i_sys_rst synchronous active high
`timescale 1ns/100ps
module pin_edge_detect (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	// pin
	input wire logic i_pin,
	// edges out
	pin_edge_if.det edge_o
);
	import gpio_map_pkg::*;
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic meta; // first stage, read only by the second
		logic sync; // settled sample
		logic prev; // previous settled sample
	} edge_state_t;
	edge_state_t q, d;
	// next state: shift the pin through the chain
	always_comb begin
		d = q;
		d.meta = i_pin;
		d.sync = q.meta;
		d.prev = q.sync;
	end
	// registers
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
	// edges from successive settled samples
	assign edge_o.level = q.sync;
	assign edge_o.rise = q.sync & ~q.prev;
	assign edge_o.fall = ~q.sync & q.prev;
endmodule : pin_edge_detect

// ---- logic/pin_edge_if.sv ----
// pin level and edge carrier between the edge detector and the mapper
// assumes both ends run on the core clock
`timescale 1ns/100ps
interface pin_edge_if;
	logic level; // sampled pin level
	logic rise; // one-cycle rising edge
	logic fall; // one-cycle falling edge
	modport det (output level, output rise, output fall);
	modport use_side (input level, input rise, input fall);
endinterface : pin_edge_if

// ---- tb/gpio_map_monitor.sv ----
// checker for the gpio function mapper top ports
// assumes one core clock and a synchronous active-high reset
`timescale 1ns/100ps
module gpio_map_monitor (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	// register bus
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic o_avs_waitrequest,
	// triggers and levels
	input wire logic o_sleep_enter,
	input wire logic o_sleep_exit,
	input wire logic o_deep_sleep,
	input wire logic o_fault_dump,
	input wire logic o_protect,
	input wire logic o_output_clear_trigger,
	input wire logic o_device_reset,
	input wire logic o_nvm_prog,
	input wire logic o_nvm_prog_allowed,
	input wire logic o_reg_write_allowed,
	input wire logic o_gpio_oe,
	input wire logic [gpio_map_pkg::NCH-1:0] o_output_load_trigger
);
	import gpio_map_pkg::*;
	// --------
	// properties
	// --------
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_sys_rst);
	// request still waiting
	sequence s_taken;
		(i_avs_read || i_avs_write) && o_avs_waitrequest;
	endsequence
	// answer cycle
	sequence s_ans;
		(i_avs_read || i_avs_write) && !o_avs_waitrequest;
	endsequence
	// fault dump, protect or clear pulse
	sequence s_dev;
		o_fault_dump || o_protect || o_output_clear_trigger;
	endsequence
	property p_bus_ans;
		s_taken |=> s_ans;
	endproperty
	property p_bus_one;
		s_ans |=> o_avs_waitrequest || !(i_avs_read || i_avs_write);
	endproperty
	property p_pulse;
		s_dev |=> !(o_fault_dump || o_protect || o_output_clear_trigger);
	endproperty
	property p_load;
		(o_output_load_trigger != 2'h0) |=> (o_output_load_trigger == 2'h0);
	endproperty
	property p_sleep;
		o_sleep_enter |-> !o_sleep_exit;
	endproperty
	property p_dflt;
		$fell(i_sys_rst) |-> o_reg_write_allowed && o_nvm_prog_allowed && !o_gpio_oe && !o_deep_sleep;
	endproperty
	property p_quiet;
		$fell(i_sys_rst) |-> (!(o_fault_dump || o_protect || o_device_reset))[*3];
	endproperty
	property p_nvm;
		o_nvm_prog |-> o_nvm_prog_allowed;
	endproperty
	property p_rst;
		o_device_reset |=> (!o_device_reset)[*3];
	endproperty
	a_bus_ans: assert property (p_bus_ans) else $error("bus answer late");
	a_bus_one: assert property (p_bus_one) else $error("bus answer repeated");
	a_pulse: assert property (p_pulse) else $error("device pulse too long");
	a_load: assert property (p_load) else $error("load pulse too long");
	a_sleep: assert property (p_sleep) else $error("sleep enter and exit together");
	a_dflt: assert property (p_dflt) else $error("bad levels after reset");
	a_quiet: assert property (p_quiet) else $error("pulse during load");
	a_nvm: assert property (p_nvm) else $error("nvm program while blocked");
	a_rst: assert property (p_rst) else $error("reset pulse repeated");
endmodule : gpio_map_monitor
bind gpio_function_mapper gpio_map_monitor mon (.i_core_clk, .i_sys_rst, .i_avs_read,
	.i_avs_write, .o_avs_waitrequest, .o_sleep_enter, .o_sleep_exit, .o_deep_sleep,
	.o_fault_dump, .o_protect, .o_output_clear_trigger, .o_device_reset, .o_nvm_prog,
	.o_nvm_prog_allowed, .o_reg_write_allowed, .o_gpio_oe, .o_output_load_trigger);

// ---- tb/pin_drv.sv ----
// external driver model for the general-purpose pin
// assumes the bench calls its tasks on the core clock
`timescale 1ns/100ps
module pin_drv (
	// clock
	input wire logic i_core_clk,
	// pin
	output logic o_pin
);
	// idle high, an unused pin is tied to a level
	initial o_pin = 1'b1;
	// move the pin just after a rising edge
	task set(input logic v);
		@(posedge i_core_clk);
		o_pin <= v;
	endtask : set
	// active-low pulse of n cycles
	task pulse(input int n);
		set(1'b0);
		repeat (n) @(posedge i_core_clk);
		o_pin <= 1'b1;
	endtask : pulse
endmodule : pin_drv

// ---- tb/tb_top.sv ----
// self-checking bench for the gpio function mapper
// assumes the package, interface and design files compile first
`timescale 1ns/100ps
module tb_top;
	import gpio_map_pkg::*;
	// --------
	// signals
	// --------
	localparam logic [11:0] TBL [8] = '{12'h902, 12'hA86, 12'hB8A, 12'hC32,
		12'hC34, 12'hD5E, 12'hD58, 12'h100};
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [ADDR_W-1:0] adr = 4'h0;
	logic ren = 1'b0;
	logic wen = 1'b0;
	logic [DATA_W-1:0] wd = 32'h0;
	logic [DATA_W-1:0] rdat;
	logic [CFG_W-1:0] nvm = 16'h0000;
	logic nbusy = 1'b0;
	logic wrq, pin, oe, gout, dsl, fd, pr, clr, drst, nva, rwa, se, sx, npg;
	logic [NCH-1:0] ld, mlo, mhi, iop, vop, frun;
	logic [2*NCH-1:0] vps;
	logic [12:0] pv;
	logic [11:0] e;
	logic [31:0] r;
	int pc [13];
	int snap;
	int err_count = 0;
	int checks = 0;
	int cyc = 0;
	gpio_function_mapper uut (.i_core_clk(clk), .i_sys_rst(rst), .i_avs_address(adr),
		.i_avs_read(ren), .i_avs_write(wen), .i_avs_writedata(wd), .o_avs_readdata(rdat),
		.o_avs_waitrequest(wrq), .i_nvm_cfg(nvm), .i_nvm_busy(nbusy), .i_dac_busy(2'h0),
		.i_win_cmp(2'h0), .i_gpio_in(pin), .o_gpio_out(gout), .o_gpio_oe(oe),
		.o_sleep_enter(se), .o_sleep_exit(sx), .o_deep_sleep(dsl), .o_fault_dump(fd),
		.o_protect(pr), .o_output_clear_trigger(clr), .o_device_reset(drst),
		.o_nvm_prog(npg), .o_nvm_prog_allowed(nva), .o_reg_write_allowed(rwa),
		.o_output_load_trigger(ld), .o_margin_low(mlo), .o_margin_high(mhi),
		.o_iout_pd(iop), .o_vout_pd(vop),
		.o_voltage_powerdown_setting(vps), .o_func_run(frun));
	pin_drv drv (.i_core_clk(clk), .o_pin(pin));
	// clock and pulse counters, one slot per trigger output bit
	initial forever #4 clk = ~clk;
	assign pv = {sx, se, mhi, npg, mlo, ld, drst, clr, pr, fd};
	always @(posedge clk) begin
		for (int i = 0; i < 13; i++) if (pv[i] === 1'b1) pc[i]++;
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			finish_test();
		end
	end
	// compare one value
	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// one bus access, held until the edge that samples waitrequest low
	task acc(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		adr <= a;
		wd <= d;
		wen <= w;
		ren <= !w;
		do begin
			@(posedge clk);
		end while (wrq !== 1'b0);
		r = rdat;
		wen <= 1'b0;
		ren <= 1'b0;
	endtask : acc
	// move the pin and let the triggers settle
	task pn(input logic v);
		drv.set(v);
		repeat (8) @(posedge clk);
	endtask : pn
	// reset and wait for run
	task do_reset();
		@(posedge clk);
		rst <= 1'b1;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (12) @(posedge clk);
	endtask : do_reset
	// level outputs by selector
	function logic [1:0] obs(input int s);
		case (s)
			0: obs = {1'b0, dsl};
			1: obs = iop;
			2: obs = vop;
			3: obs = frun;
			4: obs = {1'b0, nva};
			default: obs = {1'b0, rwa};
		endcase
	endfunction : obs
	// fall then rise on a level function
	task lv(input logic [15:0] w, input int s, input logic [1:0] f, input logic [1:0] q);
		acc(1'b1, OFF_CFG, {16'h0, w});
		pn(1'b0);
		chk("level fall", {30'h0, obs(s)}, {30'h0, f});
		pn(1'b1);
		chk("level rise", {30'h0, obs(s)}, {30'h0, q});
	endtask : lv
	// verdict
	task finish_test();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : finish_test
	// main sequence
	initial begin
		do_reset();
		acc(1'b0, OFF_CFG, 32'h0);
		chk("cfg reset", r, {16'h0, CFG_RESET});
		acc(1'b0, 4'h2, 32'h0);
		chk("unmapped", r, 32'h0);
		acc(1'b0, OFF_TRIG, 32'h0);
		chk("trigger read", r, 32'h0);
		acc(1'b1, OFF_CHCFG, 32'h39);
		acc(1'b0, OFF_CHCFG, 32'h0);
		chk("chcfg", r, 32'h39);
		chk("pdn setting", {28'h0, vps}, 32'h9);
		$display("registers done");
		for (int k = 0; k < 8; k++) begin
			e = TBL[k];
			acc(1'b1, OFF_CFG, {25'h0, e[6:5], e[10:7], e[11]});
			snap = pc[e[4:2]];
			pn(1'b0);
			chk("edge fall", pc[e[4:2]] - snap, {31'h0, e[1]});
			pn(1'b1);
			chk("edge rise", pc[e[4:2]] - snap, {31'h0, e[1]});
		end
		$display("edge table done");
		snap = pc[11] + pc[12];
		lv(16'h4001, 0, 2'h1, 2'h0);
		chk("sleep pulses", pc[11] + pc[12] - snap, 32'h2);
		lv(16'h0047, 1, 2'h2, 2'h0);
		lv(16'h0029, 2, 2'h1, 2'h0);
		lv(16'h0073, 3, 2'h0, 2'h3);
		lv(16'h0019, 4, 2'h1, 2'h0);
		lv(16'h001B, 5, 2'h1, 2'h0);
		acc(1'b1, OFF_CHCFG, 32'h0);
		acc(1'b0, OFF_CHCFG, 32'h0);
		chk("locked write", r, 32'h39);
		pn(1'b0);
		acc(1'b1, OFF_CFG, 32'h0);
		pn(1'b1);
		snap = pc[8];
		acc(1'b1, OFF_TRIG, 32'h1 << TRG_NVM);
		repeat (4) @(posedge clk);
		chk("nvm blocked", pc[8] - snap, 32'h0);
		acc(1'b1, OFF_CFG, 32'h19);
		pn(1'b0);
		acc(1'b1, OFF_TRIG, 32'h1 << TRG_NVM);
		repeat (4) @(posedge clk);
		chk("nvm allowed", pc[8] - snap, 32'h1);
		pn(1'b1);
		acc(1'b1, OFF_CFG, 32'h35);
		snap = pc[9];
		pn(1'b0);
		pn(1'b1);
		chk("margin high", pc[9] - snap, 32'h1);
		$display("level functions done");
		acc(1'b1, OFF_CFG, 32'h5);
		snap = pc[0];
		acc(1'b1, OFF_TRIG, 32'h1 << TRG_FAULT);
		repeat (4) @(posedge clk);
		chk("mapped soft bit", pc[0] - snap, 32'h0);
		acc(1'b1, OFF_CFG, 32'h0);
		acc(1'b1, OFF_TRIG, 32'h1 << TRG_FAULT);
		repeat (4) @(posedge clk);
		chk("free soft bit", pc[0] - snap, 32'h1);
		nbusy <= 1'b1;
		acc(1'b1, OFF_CFG, 32'h2205);
		snap = pc[0];
		pn(1'b0);
		pn(1'b1);
		chk("output enable", {31'h0, oe}, 32'h1);
		chk("status out", {31'h0, gout}, 32'h1);
		chk("output ignores pin", pc[0] - snap, 32'h0);
		$display("software and output done");
		acc(1'b1, OFF_CFG, 32'h17);
		snap = pc[3];
		drv.pulse(4);
		repeat (8) @(posedge clk);
		chk("reset from regs", pc[3] - snap, 32'h0);
		nvm <= 16'h0017;
		do_reset();
		drv.pulse(4);
		repeat (24) @(posedge clk);
		chk("reset from nvm", pc[3] - snap, 32'h1);
		acc(1'b0, OFF_CFG, 32'h0);
		chk("cfg reloaded", r, 32'h17);
		nvm <= 16'h0027;
		drv.set(1'b0);
		do_reset();
		chk("power-on level", {30'h0, iop}, 32'h1);
		acc(1'b0, OFF_STAT, 32'h0);
		chk("status word", r, 32'h1810);
		$display("reset and power-on done");
		finish_test();
	end
endmodule : tb_top
